// [inc/erb_pkg.sv]
package erb_pkg;
	// ----------------------------------------
	// block sizes
	// ----------------------------------------
	localparam int SIZE_SMALL = 0;
	localparam int SIZE_MEDIUM = 1;
	localparam int SIZE_LARGE = 2;
	// widest organisations: words and bits
	localparam int SMALL_WORDS = 32;
	localparam int SMALL_BITS = 18;
	localparam int MEDIUM_WORDS = 128;
	localparam int MEDIUM_BITS = 36;
	localparam int LARGE_WORDS = 4096;
	localparam int LARGE_BITS = 144;
	// ----------------------------------------
	// modes
	// ----------------------------------------
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_SIMPLE_DP = 2'h1;
	localparam logic [1:0] MODE_TRUE_DP = 2'h2;
	localparam logic [1:0] MODE_ROM = 2'h3;
	localparam int BYTE_BITS = 8;
	localparam int BYTE_PAR_BITS = 9;
	localparam logic [143:0] DATA_RESET = 144'h0;
endpackage : erb_pkg

// [rtl/erb_out_stage.sv]
`timescale 1ns/1ps
// ----------------------------------------
// read data output stage
// ----------------------------------------
module erb_out_stage #(
	parameter int W = 18,
	parameter bit REG_OUT = 1'b1,
	parameter bit HAS_CLR = 1'b1
) (
	// clock and control
	input wire logic clk_in,
	input wire logic ce_in,
	input wire logic clr_in,
	// data
	input wire logic [W-1:0] raw_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] q_q;
	logic clr;
	// a stage without clear must not see a stray clear either
	assign clr = clr_in && HAS_CLR;
	// clear is visible at once, without a clock edge
	always_ff @(posedge clk_in or posedge clr) begin
		if (clr) begin
			q_q <= '0;
		end else if (ce_in) begin
			q_q <= raw_in;
		end
	end
	// bypass hands array data straight through
	assign q_out = REG_OUT ? q_q : raw_in;
endmodule : erb_out_stage

// [rtl/erb_ram.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - three sizes: 32x18, 128x36, 4Kx144
// - single, simple dual, rom; parity optional
// - medium/large true dual port, independent ports
// - small/medium clear in and out; large out
// - large block cannot be preloaded
// - inputs registered; output register optional
// - simple dual: read+write; collision old/undefined
// - single port: read or write, not both
// - single port write shows new word
// - dual port ports may differ in width
// - internal write strobe from ref_clk_in
// - output register bypass option
// - flow-through read (port b, not large) latches on falling edge
// - medium holds two half-size single ports
// - wider memories from blocks side by side
// - one parity bit per byte, user usable
// - input clear now, read shows next edge
module erb_ram #(
	parameter int SIZE = erb_pkg::SIZE_MEDIUM,
	parameter logic [1:0] MODE = erb_pkg::MODE_TRUE_DP,
	parameter bit PARITY = 1'b1,
	parameter int WA = 36,
	parameter int WB = 36,
	parameter int SLICES = 1,
	parameter bit REG_OUT = 1'b1,
	parameter bit FLOW_THRU = 1'b0,
	parameter bit OLD_DATA = 1'b1,
	parameter bit SPLIT = 1'b0,
	parameter logic [143:0] INIT_WORD = erb_pkg::DATA_RESET
) (
	// common
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic inclr_in,
	input wire logic outclr_in,
	// port a
	input wire logic clk_a_in,
	input wire logic ce_a_in,
	input wire logic [15:0] addr_a_in,
	input wire logic [WA*SLICES-1:0] data_a_in,
	input wire logic wren_a_in,
	input wire logic rden_a_in,
	output logic [WA*SLICES-1:0] q_a_out,
	// port b
	input wire logic clk_b_in,
	input wire logic ce_b_in,
	input wire logic [15:0] addr_b_in,
	input wire logic [WB*SLICES-1:0] data_b_in,
	input wire logic wren_b_in,
	input wire logic rden_b_in,
	output logic [WB*SLICES-1:0] q_b_out
);
	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int BITS = (SIZE == erb_pkg::SIZE_SMALL) ?
		erb_pkg::SMALL_WORDS * erb_pkg::SMALL_BITS :
		(SIZE == erb_pkg::SIZE_MEDIUM) ?
		erb_pkg::MEDIUM_WORDS * erb_pkg::MEDIUM_BITS :
		erb_pkg::LARGE_WORDS * erb_pkg::LARGE_BITS;
	// without parity the ninth bit of each byte is left unused
	localparam int UNIT = PARITY ? erb_pkg::BYTE_PAR_BITS :
		erb_pkg::BYTE_BITS;
	localparam int NA = BITS / WA;
	localparam int NB = BITS / WB;
	localparam bit TDP = (MODE == erb_pkg::MODE_TRUE_DP) &&
		(SIZE != erb_pkg::SIZE_SMALL);
	localparam bit INCLR = (SIZE != erb_pkg::SIZE_LARGE);
	localparam bit PRELOAD = (SIZE != erb_pkg::SIZE_LARGE);
	localparam bit ROM = (MODE == erb_pkg::MODE_ROM);
	localparam bit SINGLE = (MODE == erb_pkg::MODE_SINGLE);
	localparam int HALF = BITS / 2;
	localparam int FILL = BITS / erb_pkg::LARGE_BITS;

	// large size ignores the input clear altogether
	logic in_clr;
	logic out_clr;
	assign in_clr = inclr_in && INCLR;
	// outputs come up cleared on sizes that preload
	assign out_clr = outclr_in || (rst_in && PRELOAD);

	function automatic int unsigned bit_base(input logic [15:0] a,
		input int w, input int n);
		int unsigned idx;
		idx = 32'(a) % 32'(n);
		bit_base = idx * 32'(w);
	endfunction : bit_base

	// ----------------------------------------
	// slices placed side by side
	// ----------------------------------------
	genvar s;
	generate
	for (s = 0; s < SLICES; s++) begin : g_slice
		logic [BITS-1:0] mem_q;
		logic [15:0] ra_q, rb_q, wa_q, wb_q;
		logic [WA-1:0] da_q;
		logic [WB-1:0] db_q;
		logic wea_q, web_q, rea_q, reb_q;
		logic [15:0] fa_q;
		logic fre_q;
		logic [WA-1:0] rawa;
		logic [WB-1:0] rawb;
		logic [15:0] addr_rd_b;
		logic rd_en_b;
		logic init_done_q;

		// input registers on the port clock; the array write itself follows ref_clk_in
		always_ff @(posedge clk_a_in or posedge in_clr) begin
			if (in_clr) begin
				wa_q <= 16'h0000;
				da_q <= '0;
				wea_q <= 1'b0;
				rea_q <= 1'b0;
				ra_q <= 16'h0000;
			end else if (ce_in && ce_a_in) begin
				wa_q <= addr_a_in;
				ra_q <= addr_a_in;
				da_q <= data_a_in[s*WA +: WA];
				// single port: a write excludes the read
				wea_q <= wren_a_in && !ROM;
				rea_q <= rden_a_in && !(SINGLE && wren_a_in);
			end
		end

		always_ff @(posedge clk_b_in or posedge in_clr) begin
			if (in_clr) begin
				wb_q <= 16'h0000;
				db_q <= '0;
				web_q <= 1'b0;
				reb_q <= 1'b0;
				rb_q <= 16'h0000;
			end else if (ce_in && ce_b_in) begin
				wb_q <= addr_b_in;
				rb_q <= addr_b_in;
				db_q <= data_b_in[s*WB +: WB];
				web_q <= wren_b_in && TDP;
				reb_q <= rden_b_in && !SINGLE;
			end
		end

		// flow-through read path on the falling edge
		always_ff @(negedge clk_b_in) begin
			if (ce_in && ce_b_in) begin
				fa_q <= addr_b_in;
				fre_q <= rden_b_in;
			end
		end
		assign addr_rd_b = (FLOW_THRU && SIZE != erb_pkg::SIZE_LARGE)
			? fa_q : rb_q;
		assign rd_en_b = (FLOW_THRU && SIZE != erb_pkg::SIZE_LARGE)
			? fre_q : reb_q;

		// array; the write strobe is derived from ref_clk_in,
		// so user logic only supplies a registered enable
		always_ff @(posedge ref_clk_in) begin
			if (rst_in) begin
				init_done_q <= 1'b0;
				if (PRELOAD) begin
					// init word repeats over the whole array
					mem_q <= {FILL{INIT_WORD}};
				end
			end else if (ce_in) begin
				init_done_q <= 1'b1;
				if (wea_q && (!SPLIT || bit_base(wa_q, WA, NA) < HALF))
				begin
					mem_q[bit_base(wa_q, WA, NA) +: WA] <= da_q;
				end
				if (web_q && (!SPLIT || bit_base(wb_q, WB, NB) >= HALF))
				begin
					mem_q[bit_base(wb_q, WB, NB) +: WB] <= db_q;
				end
			end
		end

		// single port read-back sees the stored word at once
		always_comb begin
			rawa = mem_q[bit_base(ra_q, WA, NA) +: WA];
			if (SINGLE && wea_q) begin
				rawa = da_q;
			end
		end
		// collision: previous contents or undefined
		always_comb begin
			rawb = mem_q[bit_base(addr_rd_b, WB, NB) +: WB];
			if (!OLD_DATA && wea_q && wa_q == addr_rd_b && rd_en_b) begin
				rawb = 'x;
			end
		end

		erb_out_stage #(
			.W(WA),
			.REG_OUT(REG_OUT),
			.HAS_CLR(1'b1)
		) u_out_a (
			.clk_in(clk_a_in),
			// single port write refreshes the read register
			.ce_in(ce_in && (rea_q || (SINGLE && wea_q))),
			.clr_in(out_clr),
			.raw_in(rawa),
			.q_out(q_a_out[s*WA +: WA])
		);
		erb_out_stage #(
			.W(WB),
			.REG_OUT(REG_OUT && !FLOW_THRU),
			.HAS_CLR(1'b1)
		) u_out_b (
			.clk_in(clk_b_in),
			.ce_in(ce_in && rd_en_b),
			.clr_in(out_clr),
			.raw_in(rawb),
			.q_out(q_b_out[s*WB +: WB])
		);

		// ----------------------------------------
		// checks
		// ----------------------------------------
		property p_single_one_op;
			@(posedge clk_a_in) disable iff (rst_in)
			SINGLE |-> !(wea_q && rea_q);
		endproperty
		a_single_one_op: assert property (p_single_one_op)
			else $error("single port read and write together");
		property p_rom_no_write;
			@(posedge clk_a_in) disable iff (rst_in)
			ROM |-> !wea_q;
		endproperty
		a_rom_no_write: assert property (p_rom_no_write)
			else $error("write in rom mode");
		property p_small_no_b_write;
			@(posedge clk_b_in) disable iff (rst_in)
			!TDP |-> !web_q;
		endproperty
		a_small_no_b_write: assert property (p_small_no_b_write)
			else $error("port b wrote outside true dual port");
		property p_in_clear;
			@(posedge clk_a_in) inclr_in && INCLR |-> !wea_q && !rea_q;
		endproperty
		a_in_clear: assert property (p_in_clear)
			else $error("input registers not cleared");
		property p_out_clear;
			@(posedge clk_a_in) outclr_in && REG_OUT |->
				q_a_out[s*WA +: WA] == '0;
		endproperty
		a_out_clear: assert property (p_out_clear)
			else $error("output register not cleared");
		property p_single_readback;
			@(posedge clk_a_in) disable iff (rst_in || outclr_in)
			SINGLE && REG_OUT && wea_q && ce_in |=>
				q_a_out[s*WA +: WA] == $past(da_q);
		endproperty
		a_single_readback: assert property (p_single_readback)
			else $error("written word not shown on read data");
		property p_init_done;
			@(posedge ref_clk_in) rst_in |=> !init_done_q;
		endproperty
		a_init_done: assert property (p_init_done)
			else $error("reset not seen by array");
		property p_bypass;
			@(posedge clk_a_in) disable iff (rst_in)
			!REG_OUT |-> q_a_out[s*WA +: WA] == rawa;
		endproperty
		a_bypass: assert property (p_bypass)
			else $error("bypassed output differs from array");
		property p_freeze;
			@(posedge ref_clk_in) disable iff (rst_in)
			!ce_in |=> $stable(mem_q);
		endproperty
		a_freeze: assert property (p_freeze)
			else $error("array changed while clock enable low");
		property p_write_lands;
			@(posedge ref_clk_in) disable iff (rst_in)
			ce_in && wea_q && !web_q && !SPLIT |=>
			mem_q[bit_base($past(wa_q), WA, NA) +: WA] == $past(da_q);
		endproperty
		a_write_lands: assert property (p_write_lands)
			else $error("port a write did not reach the array");
		property p_in_clear_b;
			@(posedge clk_b_in) in_clr |-> !web_q && !reb_q;
		endproperty
		a_in_clear_b: assert property (p_in_clear_b)
			else $error("port b input registers not cleared");
		property p_out_clear_b;
			@(posedge clk_b_in) outclr_in && REG_OUT && !FLOW_THRU |->
				q_b_out[s*WB +: WB] == '0;
		endproperty
		a_out_clear_b: assert property (p_out_clear_b)
			else $error("port b output register not cleared");
		property p_power_up;
			@(posedge clk_a_in) rst_in && PRELOAD && REG_OUT |=>
				q_a_out[s*WA +: WA] == '0;
		endproperty
		a_power_up: assert property (p_power_up)
			else $error("output not cleared at power-up");
		c_write_a: cover property (@(posedge clk_a_in) wea_q);
		c_read_b: cover property (@(posedge clk_b_in) rd_en_b);
		c_both: cover property (@(posedge clk_a_in) wea_q && rea_q);
		c_out_clear: cover property (@(posedge clk_b_in) outclr_in);
		c_freeze: cover property (@(posedge ref_clk_in) !ce_in);
	end
	endgenerate
endmodule : erb_ram

// [testbench/erb_user_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// user logic driving both ram ports
// ----------------------------------------
module erb_user_model (
	// clock
	input wire logic clk_in,
	// port a
	output logic [15:0] addr_a_out,
	output logic [35:0] data_a_out,
	output logic wren_a_out,
	output logic rden_a_out,
	// port b
	output logic [15:0] addr_b_out,
	output logic [35:0] data_b_out,
	output logic wren_b_out,
	output logic rden_b_out
);
	initial begin
		{addr_a_out, data_a_out, wren_a_out, rden_a_out} = '0;
		{addr_b_out, data_b_out, wren_b_out, rden_b_out} = '0;
	end
	// one op a call; read and write never both on one port
	task automatic access(input bit p, input bit wr,
		input logic [15:0] a, input logic [35:0] d);
		@(posedge clk_in);
		if (!p) begin
			addr_a_out <= a;
			data_a_out <= d;
			wren_a_out <= wr;
			rden_a_out <= !wr;
		end else begin
			addr_b_out <= b_fix(a);
			data_b_out <= d;
			wren_b_out <= wr;
			rden_b_out <= !wr;
		end
		@(posedge clk_in);
		// idle write enables stay low; stale data inverted
		{wren_a_out, rden_a_out, wren_b_out, rden_b_out} <= '0;
		data_a_out <= ~data_a_out;
		data_b_out <= ~data_b_out;
		addr_a_out <= ~addr_a_out;
		addr_b_out <= ~addr_b_out;
	endtask : access
	function automatic logic [15:0] b_fix(input logic [15:0] a);
		return a;
	endfunction : b_fix
endmodule : erb_user_model

// [testbench/tb_top.sv]
`timescale 1ns/1ps
// ----------------------------------------
// bench for medium true dual port ram
// ----------------------------------------
module tb_top;
	localparam logic [35:0] INIT_LO = 36'h9_a5c3_1e07;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic ce_in = 1'b1;
	logic outclr_in = 1'b0;
	logic inclr_in = 1'b0;
	logic [15:0] addr_a, addr_b;
	logic [35:0] data_a, data_b, q_a, q_b;
	logic wren_a, rden_a, wren_b, rden_b;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	always #10 ref_clk_in = ~ref_clk_in;
	erb_user_model u_usr (.clk_in(ref_clk_in), .addr_a_out(addr_a),
		.data_a_out(data_a), .wren_a_out(wren_a), .rden_a_out(rden_a),
		.addr_b_out(addr_b), .data_b_out(data_b), .wren_b_out(wren_b),
		.rden_b_out(rden_b));
	erb_ram #(.INIT_WORD({4{INIT_LO}})) u_dut (.ref_clk_in(ref_clk_in),
		.rst_in(rst_in), .ce_in(ce_in), .inclr_in(inclr_in),
		.outclr_in(outclr_in), .clk_a_in(ref_clk_in), .ce_a_in(1'b1),
		.addr_a_in(addr_a), .data_a_in(data_a), .wren_a_in(wren_a),
		.rden_a_in(rden_a), .q_a_out(q_a), .clk_b_in(ref_clk_in),
		.ce_b_in(1'b1), .addr_b_in(addr_b), .data_b_in(data_b),
		.wren_b_in(wren_b), .rden_b_in(rden_b), .q_b_out(q_b));
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	// read lands one edge after it is taken; q then stands
	task automatic rd_chk(input bit p, input logic [15:0] a,
		input logic [35:0] exp);
		u_usr.access(p, 1'b0, a, 36'h0);
		repeat (2) @(posedge ref_clk_in);
		#1;
		check(p ? q_b : q_a, exp);
	endtask : rd_chk
	task automatic t_power_up();
		#1;
		check(q_a, 36'h0);
		check(q_b, 36'h0);
		rd_chk(1'b1, 16'h0007, INIT_LO);
	endtask : t_power_up
	task automatic t_dual_port();
		u_usr.access(1'b0, 1'b1, 16'h000a, 36'h1_2345_6789);
		u_usr.access(1'b1, 1'b1, 16'h0014, 36'hf_edcb_a987);
		rd_chk(1'b1, 16'h000a, 36'h1_2345_6789);
		rd_chk(1'b0, 16'h0014, 36'hf_edcb_a987);
	endtask : t_dual_port
	// 128 words: address 0x80 wraps onto word 0
	task automatic t_wrap();
		u_usr.access(1'b0, 1'b1, 16'h007f, 36'h0_5555_aaaa);
		u_usr.access(1'b0, 1'b1, 16'h0080, 36'h3_3333_cccc);
		rd_chk(1'b1, 16'h0000, 36'h3_3333_cccc);
		rd_chk(1'b1, 16'h007f, 36'h0_5555_aaaa);
	endtask : t_wrap
	task automatic t_clear();
		@(posedge ref_clk_in);
		outclr_in <= 1'b1;
		#1;
		check(q_b, 36'h0);
		@(posedge ref_clk_in);
		outclr_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		#1;
		check(q_b, 36'h0);
	endtask : t_clear
	// frozen clock enable: a write must not land
	task automatic t_freeze();
		@(posedge ref_clk_in);
		ce_in <= 1'b0;
		u_usr.access(1'b0, 1'b1, 16'h001e, 36'h7_0f0f_0f0f);
		@(posedge ref_clk_in);
		ce_in <= 1'b1;
		rd_chk(1'b0, 16'h001e, INIT_LO);
	endtask : t_freeze
	// input clear drops a write already taken
	task automatic t_in_clear();
		u_usr.access(1'b0, 1'b1, 16'h0028, 36'h2_4680_ace1);
		inclr_in <= 1'b1;
		@(posedge ref_clk_in);
		inclr_in <= 1'b0;
		rd_chk(1'b0, 16'h0028, INIT_LO);
	endtask : t_in_clear
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			complete_run();
		end
	end
	initial begin
		repeat (4) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		t_power_up();
		t_dual_port();
		t_wrap();
		t_clear();
		t_freeze();
		t_in_clear();
		complete_run();
	end
endmodule : tb_top
